// >>> shared/pin_mux_defines.svh
`ifndef PIN_MUX_DEFINES_SVH
`define PIN_MUX_DEFINES_SVH

// Byte addresses of the Wishbone registers
`define ADDR_CPU_CONTROL_STATUS  8'h00
`define ADDR_PORT_A_ALT_CFG      8'h04
`define ADDR_INTERFACE_CONFIG    8'h08
`define ADDR_FIFO_POLARITY       8'h0c
`define ADDR_WAKEUP_CONTROL      8'h10
`define ADDR_PORT_A_OE           8'h14
`define ADDR_PORT_A_OUT          8'h18
`define ADDR_PORT_A_IN           8'h1c
`define ADDR_IRQ_STATUS          8'h20
`define ADDR_IRQ_MASK            8'h24
`define ADDR_STATE               8'h28
`define ADDR_IRQ_SENSE           8'h2c

// Field positions
`define CPU_CTRL_CPU_CLOCK_OUTPUT_TRI  1
`define CPU_CTRL_RATE_LO     3
`define ALT_IRQ0          0
`define ALT_IRQ1          1
`define POL_OE            4
`define POL_COMMIT        5
`define WAKE_PIN2_EN      1
`define WAKE_PIN2_POL     4
`define WAKE_PIN2_SEL     7
`define OE_BIT3           3

// Interface mode code that hands Port A pins 2, 4, 5 and 6 to the slave FIFO
`define IFC_SLAVE_FIFO    2'h3

// Reset values
`define CPU_CTRL_RESET    8'h00
`define IFC_RESET         8'h00
`define POL_RESET         8'h00
`define WAKE_RESET        8'h00

// Status bits
`define ST_IRQ0    0
`define ST_IRQ1    1
`define ST_WAKE    2
`define ST_COMMIT  3

// Clock rates in MHz
`define CLK_MHZ    100

`endif

// >>> shared/pin_mux_pkg.sv
`default_nettype none
package pin_mux_pkg;
    typedef enum logic [1:0] {
        RATE_12,
        RATE_24,
        RATE_48,
        RATE_RSVD
    } clk_rate_t;

    typedef enum {
        PWR_RUN,
        PWR_SUSPEND
    } pwr_state_t;

    typedef struct packed {
        logic [7:0] cpu_ctrl;
        logic [7:0] alt_cfg;
        logic [7:0] ifc;
        logic [7:0] polarity;
        logic [7:0] wake;
        logic [6:0] pa_oe;
        logic [6:0] pa_out;
        logic [1:0] irq_sense;
        logic [3:0] irq_status;
        logic [3:0] irq_mask;
        logic       irq_o;
        logic       ack;
        logic [31:0] dat;
        logic [6:0] pa_prev;
        logic [1:0] div_cnt;
        logic       clk_out;
        logic       clk_oe;
        logic       code_ext;
        logic       suspended;
        logic       osc_on;
        logic       core_rst;
        logic       oe_fifo;
        logic [1:0] fifo_sel;
        logic       commit;
        logic [6:0] pa_drv;
        logic [6:0] pa_en;
    } mux_state_t;
endpackage
`default_nettype wire

// >>> src/port_a_alt_function_pins.sv
`include "pin_mux_defines.svh"
`default_nettype none
module port_a_alt_function_pins
    import pin_mux_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        reset_pin_n_i,
    input  wire logic        code_fetch_external_sel_i,
    input  wire logic        suspend_req_i,
    input  wire logic [6:0]  port_a_in_i,
    output logic      [6:0]  port_a_out_o,
    output logic      [6:0]  port_a_oe_o,
    output logic             cpu_clock_output_o,
    output logic             cpu_clock_output_oe_o,
    output logic             code_fetch_external_o,
    output logic             suspended_o,
    output logic             oscillator_on_o,
    output logic             chip_reset_o,
    output logic             fifo_output_enable_o,
    output logic      [1:0]  fifo_select_o,
    output logic             packet_commit_o,
    output logic             irq_o,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o
);

    mux_state_t s;
    mux_state_t next_s;

    // Divider terminal count per selected rate
    function automatic logic [1:0] rate_top(input logic [1:0] rate);
        case (rate)
            2'h1:    rate_top = 2'h1;
            2'h2:    rate_top = 2'h0;
            default: rate_top = 2'h3;
        endcase
    endfunction

    logic       req;
    logic       wr;
    logic       fifo_mode;
    logic       irq0_lvl;
    logic       irq1_lvl;
    logic       irq0_fall;
    logic       irq1_fall;
    logic       wake_sel;
    logic       wake_act;
    logic       wake_edge;
    logic       commit_act;
    logic [3:0] events;
    logic [31:0] rd;

    // Bus decode and pin function decode
    always_comb begin
        req        = wb_cyc_i && wb_stb_i && !s.ack;
        wr         = req && wb_we_i && wb_sel_i[0];
        fifo_mode  = s.ifc[1:0] == `IFC_SLAVE_FIFO;
        irq0_lvl   = !port_a_in_i[0];
        irq1_lvl   = !port_a_in_i[1];
        irq0_fall  = s.pa_prev[0] && !port_a_in_i[0];
        irq1_fall  = s.pa_prev[1] && !port_a_in_i[1];
        wake_sel   = s.wake[`WAKE_PIN2_SEL] && !s.pa_oe[`OE_BIT3];
        wake_act   = wake_sel && s.wake[`WAKE_PIN2_EN]
                     && (port_a_in_i[3] == s.wake[`WAKE_PIN2_POL]);
        wake_edge  = wake_sel && s.wake[`WAKE_PIN2_EN] && (port_a_in_i[3] != s.pa_prev[3]);
        commit_act = fifo_mode && (port_a_in_i[6] == s.polarity[`POL_COMMIT]);
        events     = '0;
        if (s.alt_cfg[`ALT_IRQ0]) begin
            events[`ST_IRQ0] = s.irq_sense[0] ? irq0_fall : irq0_lvl;
        end
        if (s.alt_cfg[`ALT_IRQ1]) begin
            events[`ST_IRQ1] = s.irq_sense[1] ? irq1_fall : irq1_lvl;
        end
        events[`ST_WAKE]   = s.suspended && wake_edge;
        events[`ST_COMMIT] = commit_act && !s.commit;
        case (wb_adr_i)
            `ADDR_CPU_CONTROL_STATUS: rd = {24'h0, s.cpu_ctrl};
            `ADDR_PORT_A_ALT_CFG:     rd = {24'h0, s.alt_cfg};
            `ADDR_INTERFACE_CONFIG:   rd = {24'h0, s.ifc};
            `ADDR_FIFO_POLARITY:      rd = {24'h0, s.polarity};
            `ADDR_WAKEUP_CONTROL:     rd = {24'h0, s.wake};
            `ADDR_PORT_A_OE:          rd = {25'h0, s.pa_oe};
            `ADDR_PORT_A_OUT:         rd = {25'h0, s.pa_out};
            `ADDR_PORT_A_IN:          rd = {25'h0, port_a_in_i};
            `ADDR_IRQ_STATUS:         rd = {28'h0, s.irq_status};
            `ADDR_IRQ_MASK:           rd = {28'h0, s.irq_mask};
            `ADDR_STATE:              rd = {29'h0, s.osc_on, s.suspended, s.code_ext};
            `ADDR_IRQ_SENSE:          rd = {30'h0, s.irq_sense};
            default:                  rd = 32'h0;
        endcase
    end

    // Next state of the whole block
    always_comb begin
        next_s         = s;
        next_s.ack     = req;
        next_s.dat     = req ? rd : 32'h0;
        next_s.pa_prev = port_a_in_i;
        if (wr) begin
            case (wb_adr_i)
                `ADDR_CPU_CONTROL_STATUS: next_s.cpu_ctrl = wb_dat_i[7:0];
                `ADDR_PORT_A_ALT_CFG:     next_s.alt_cfg  = wb_dat_i[7:0];
                `ADDR_INTERFACE_CONFIG:   next_s.ifc      = wb_dat_i[7:0];
                `ADDR_FIFO_POLARITY:      next_s.polarity = wb_dat_i[7:0];
                `ADDR_WAKEUP_CONTROL:     next_s.wake     = wb_dat_i[7:0];
                `ADDR_PORT_A_OE:          next_s.pa_oe    = wb_dat_i[6:0];
                `ADDR_PORT_A_OUT:         next_s.pa_out   = wb_dat_i[6:0];
                `ADDR_IRQ_MASK:           next_s.irq_mask = wb_dat_i[3:0];
                `ADDR_IRQ_SENSE:          next_s.irq_sense = wb_dat_i[1:0];
                default: begin
                end
            endcase
        end
        // Write one clears; a same-cycle event still sets
        if (wr && wb_adr_i == `ADDR_IRQ_STATUS) begin
            next_s.irq_status = s.irq_status & ~wb_dat_i[3:0];
        end
        next_s.irq_status = next_s.irq_status | events;
        next_s.irq_o      = |(next_s.irq_status & next_s.irq_mask);
        if (s.div_cnt >= rate_top(s.cpu_ctrl[`CPU_CTRL_RATE_LO +: 2])) begin
            next_s.div_cnt = 2'h0;
            next_s.clk_out = !s.clk_out;
        end else begin
            next_s.div_cnt = s.div_cnt + 2'h1;
        end
        next_s.clk_oe   = !s.cpu_ctrl[`CPU_CTRL_CPU_CLOCK_OUTPUT_TRI];
        next_s.code_ext = code_fetch_external_sel_i;
        if (!s.suspended && suspend_req_i && !wake_act) begin
            next_s.suspended = 1'b1;
            next_s.osc_on    = 1'b0;
        end
        if (s.suspended && wake_edge) begin
            next_s.suspended = 1'b0;
            next_s.osc_on    = 1'b1;
        end
        next_s.oe_fifo  = fifo_mode && (port_a_in_i[2] == s.polarity[`POL_OE]);
        next_s.fifo_sel = fifo_mode ? port_a_in_i[5:4] : 2'h0;
        next_s.commit   = commit_act;
        // pins driven only as plain outputs, alternates input only
        next_s.pa_en    = s.pa_oe;
        next_s.pa_drv   = s.pa_out;
        if (s.alt_cfg[`ALT_IRQ0]) next_s.pa_en[0] = 1'b0;
        if (s.alt_cfg[`ALT_IRQ1]) next_s.pa_en[1] = 1'b0;
        if (fifo_mode) begin
            next_s.pa_en[2] = 1'b0;
            next_s.pa_en[5:4] = 2'h0;
            next_s.pa_en[6] = 1'b0;
        end
        if (wake_sel) next_s.pa_en[3] = 1'b0;
        next_s.core_rst = !reset_pin_n_i;
        // reset pin resets the whole chip; code fetch select keeps following its input
        if (!reset_pin_n_i) begin
            next_s          = '0;
            next_s.core_rst = 1'b1;
            next_s.osc_on   = 1'b1;
            next_s.clk_oe   = 1'b1;
            next_s.code_ext = code_fetch_external_sel_i;
        end
    end

    // State register; reset gives 12 MHz rate code
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s          <= '0;
            s.cpu_ctrl <= `CPU_CTRL_RESET;
            s.ifc      <= `IFC_RESET;
            s.polarity <= `POL_RESET;
            s.wake     <= `WAKE_RESET;
            s.osc_on   <= 1'b1;
            s.clk_oe   <= 1'b1;
            s.pa_prev  <= 7'h7f;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from the state register
    assign port_a_out_o          = s.pa_drv;
    assign port_a_oe_o           = s.pa_en;
    assign cpu_clock_output_o    = s.clk_out;
    assign cpu_clock_output_oe_o = s.clk_oe;
    assign code_fetch_external_o = s.code_ext;
    assign suspended_o           = s.suspended;
    assign oscillator_on_o       = s.osc_on;
    assign chip_reset_o          = s.core_rst;
    assign fifo_output_enable_o  = s.oe_fifo;
    assign fifo_select_o         = s.fifo_sel;
    assign packet_commit_o       = s.commit;
    assign irq_o                 = s.irq_o;
    assign wb_dat_o              = s.dat;
    assign wb_ack_o              = s.ack;

endmodule
`default_nettype wire

// >>> sim/port_a_alt_function_pins_assertions.sv
`default_nettype none
module pin_mux_checker (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       reset_pin_n_i,
    input wire logic       code_fetch_external_sel_i,
    input wire logic       suspend_req_i,
    input wire logic [6:0] port_a_in_i,
    input wire logic [6:0] port_a_oe_o,
    input wire logic       cpu_clock_output_oe_o,
    input wire logic       code_fetch_external_o,
    input wire logic       suspended_o,
    input wire logic       chip_reset_o,
    input wire logic [1:0] fifo_select_o,
    input wire logic       irq_o,
    input wire logic       wb_cyc_i,
    input wire logic       wb_stb_i,
    input wire logic       wb_we_i,
    input wire logic       wb_ack_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking dc @(posedge clk_i); endclocking
    // Reset pin clears the bus side too, so it pauses checks
    default disable iff (rst_i || !reset_pin_n_i);
    // Bus answer timing
    property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("bus ack missing");
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("bus ack too long");
    // Pin level checks; only the chip reset and code fetch checks are not paused by the reset pin
    property p_chip_reset; disable iff (rst_i) 1 |=> chip_reset_o == !$past(reset_pin_n_i); endproperty
    a_chip_reset: assert property (p_chip_reset) else $error("chip reset wrong");
    property p_code_fetch; disable iff (rst_i) 1 |=> code_fetch_external_o == $past(code_fetch_external_sel_i); endproperty
    a_code_fetch: assert property (p_code_fetch) else $error("code fetch select wrong");
    property p_rst_inputs; $fell(rst_i) |-> port_a_oe_o == 7'h00; endproperty
    a_rst_inputs: assert property (p_rst_inputs) else $error("pins not inputs after reset");
    property p_rst_clock; $fell(rst_i) |-> cpu_clock_output_oe_o; endproperty
    a_rst_clock: assert property (p_rst_clock) else $error("clock output off after reset");
    property p_suspend_cause; $rose(suspended_o) |-> $past(suspend_req_i); endproperty
    a_suspend_cause: assert property (p_suspend_cause) else $error("suspend without request");
    property p_fifo_sel; fifo_select_o != 2'h0 |-> fifo_select_o == $past(port_a_in_i[5:4]); endproperty
    a_fifo_sel: assert property (p_fifo_sel) else $error("fifo select not from pins");
    c_write: cover property (wb_ack_o && wb_we_i);
    c_suspend: cover property ($rose(suspended_o));
    c_irq: cover property ($rose(irq_o));
endmodule
bind port_a_alt_function_pins pin_mux_checker chk (.clk_i, .rst_i, .reset_pin_n_i, .code_fetch_external_sel_i,
    .suspend_req_i, .port_a_in_i, .port_a_oe_o, .cpu_clock_output_oe_o, .code_fetch_external_o, .suspended_o,
    .chip_reset_o, .fifo_select_o, .irq_o, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o);
`default_nettype wire

// >>> sim/pin_source_model.sv
`default_nettype none
module pin_source_model (
    input  wire logic [1:0] irq_n_i,
    input  wire logic       wake_i,
    input  wire logic       act_i,
    input  wire logic [1:0] sel_i,
    input  wire logic [1:0] pol_i,
    output logic      [6:0] pins_o
);
    timeunit 1ns;
    timeprecision 1ns;
    assign pins_o = {act_i ~^ pol_i[1], sel_i, wake_i, act_i ~^ pol_i[0], irq_n_i};
endmodule
`default_nettype wire

// >>> sim/port_a_alt_function_pins_tb_top.sv
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; $display("wrong value at %0t: %h %h", $time, (a), (b)); end end
module port_a_alt_function_pins_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i = 1'b0, rst_i = 1'b1, pin_rst_n = 1'b1, code_sel = 1'b0, susp = 1'b0;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, wake = 1'b0, act = 1'b0;
    logic [1:0]  irq_n = 2'h3, fsel = 2'h0, pol = 2'h0, fifo_sel;
    logic [7:0]  adr = 8'h00, per;
    logic [31:0] wdat = 32'h0, rdat, dat_o;
    logic [6:0]  pa_in, pa_oe, pa_out;
    logic        clk_out, clk_oe, code_ext, suspended, osc, chip_rst, fifo_oe, commit, irq, ack;
    int          failures = 0, checked = 0;

    pin_source_model src (.irq_n_i(irq_n), .wake_i(wake), .act_i(act), .sel_i(fsel), .pol_i(pol), .pins_o(pa_in));
    port_a_alt_function_pins dut (.clk_i, .rst_i, .reset_pin_n_i(pin_rst_n), .code_fetch_external_sel_i(code_sel),
        .suspend_req_i(susp), .port_a_in_i(pa_in), .port_a_out_o(pa_out), .port_a_oe_o(pa_oe),
        .cpu_clock_output_o(clk_out),
        .cpu_clock_output_oe_o(clk_oe), .code_fetch_external_o(code_ext), .suspended_o(suspended),
        .oscillator_on_o(osc), .chip_reset_o(chip_rst), .fifo_output_enable_o(fifo_oe), .fifo_select_o(fifo_sel),
        .packet_commit_o(commit), .irq_o(irq), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack));

    // 100 MHz
    always #5 clk_i = ~clk_i;

    task automatic results();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // One classic cycle; a slave that never answers ends the run
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            failures++;
            results();
        end
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    // Cycles between two clock output rises; first rise skipped as it may straddle a rate change
    task automatic period(output logic [7:0] p);
        int n, t0, rises;
        logic prev;
        n = 0;
        t0 = 0;
        rises = 0;
        prev = clk_out;
        while (rises < 3 && n < 300) begin
            @(posedge clk_i);
            n++;
            if (clk_out && !prev)
                rises++;
            if (clk_out && !prev && rises == 2)
                t0 = n;
            prev = clk_out;
        end
        p = (rises == 3) ? 8'(n - t0) : 8'hff;
    endtask

    task automatic t_defaults();
        wb(1'b0, 8'h00, 8'h00);
        `CHK(rdat[7:0], 8'h00)
        wb(1'b1, 8'h3c, 8'hff);
        wb(1'b0, 8'h3c, 8'h00);
        `CHK(rdat, 32'h0)
        `CHK({pa_oe, clk_oe}, 8'h01)
    endtask

    // Plain pins drive; an alternate function forces its pin to input
    task automatic t_gpio();
        wb(1'b1, 8'h18, 8'h55);
        wb(1'b1, 8'h14, 8'h7f);
        repeat (2) @(posedge clk_i);
        `CHK({pa_out, pa_oe}, 14'h2aff)
        wb(1'b1, 8'h04, 8'h03);
        repeat (2) @(posedge clk_i);
        `CHK(pa_oe, 7'h7c)
        wb(1'b1, 8'h04, 8'h00);
        wb(1'b1, 8'h14, 8'h00);
    endtask

    task automatic t_clock();
        for (int r = 0; r < 3; r++) begin
            wb(1'b1, 8'h00, 8'(r << 3));
            period(per);
            `CHK(per, 8'd8 >> r)
        end
        wb(1'b1, 8'h00, 8'h02);
        repeat (3) @(posedge clk_i);
        `CHK(clk_oe, 1'b0)
        wb(1'b1, 8'h00, 8'h00);
    endtask

    // Level on line 0, edge on line 1; clearing while held low tells them apart
    task automatic t_irq();
        wb(1'b1, 8'h24, 8'h0f);
        wb(1'b1, 8'h2c, 8'h02);
        irq_n <= 2'b00;
        wb(1'b0, 8'h20, 8'h00);
        `CHK(rdat[1:0], 2'b00)
        irq_n <= 2'b11;
        wb(1'b1, 8'h04, 8'h03);
        irq_n <= 2'b00;
        wb(1'b1, 8'h20, 8'h03);
        wb(1'b0, 8'h20, 8'h00);
        `CHK(rdat[1:0], 2'b01)
        `CHK(irq, 1'b1)
        wb(1'b1, 8'h24, 8'h00);
        repeat (2) @(posedge clk_i);
        `CHK(irq, 1'b0)
        irq_n <= 2'b11;
        wb(1'b1, 8'h20, 8'h0f);
        wb(1'b0, 8'h20, 8'h00);
        `CHK(rdat[1:0], 2'b00)
    endtask

    task automatic t_fifo();
        wb(1'b1, 8'h08, 8'h03);
        for (int s = 0; s < 4; s++) begin
            wb(1'b1, 8'h0c, s[0] ? 8'h30 : 8'h00);
            pol <= {2{s[0]}};
            fsel <= s[1:0];
            act <= 1'b1;
            repeat (3) @(posedge clk_i);
            `CHK(fifo_oe, 1'b1)
            `CHK(fifo_sel, s[1:0])
            `CHK(commit, 1'b1)
            act <= 1'b0;
            repeat (3) @(posedge clk_i);
            `CHK({fifo_oe, commit}, 2'b00)
        end
        wb(1'b0, 8'h20, 8'h00);
        `CHK(rdat[3], 1'b1)
        wb(1'b1, 8'h08, 8'h00);
        act <= 1'b1;
        repeat (3) @(posedge clk_i);
        `CHK({fifo_oe, commit}, 2'b00)
        act <= 1'b0;
    endtask

    task automatic t_wake();
        wake <= 1'b1;
        wb(1'b1, 8'h10, 8'h92);
        wb(1'b1, 8'h14, 8'h08);
        susp <= 1'b1;
        repeat (3) @(posedge clk_i);
        `CHK({suspended, osc}, 2'b10)
        wb(1'b1, 8'h14, 8'h00);
        susp <= 1'b0;
        wake <= 1'b0;
        repeat (3) @(posedge clk_i);
        `CHK({suspended, osc}, 2'b01)
        wb(1'b0, 8'h20, 8'h00);
        `CHK(rdat[2], 1'b1)
        wb(1'b1, 8'h10, 8'h82);
        susp <= 1'b1;
        repeat (3) @(posedge clk_i);
        `CHK(suspended, 1'b0)
        wb(1'b1, 8'h10, 8'h80);
        wake <= 1'b1;
        repeat (3) @(posedge clk_i);
        `CHK(suspended, 1'b1)
        susp <= 1'b0;
    endtask

    task automatic t_pin_reset();
        code_sel <= 1'b1;
        pin_rst_n <= 1'b0;
        repeat (3) @(posedge clk_i);
        `CHK({chip_rst, suspended, code_ext}, 3'b101)
        pin_rst_n <= 1'b1;
        repeat (2) @(posedge clk_i);
        wb(1'b0, 8'h10, 8'h00);
        `CHK(rdat[7:0], 8'h00)
        wb(1'b0, 8'h28, 8'h00);
        `CHK(rdat[2:0], 3'b101)
    endtask

    // Main sequence
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_defaults();
        t_gpio();
        t_clock();
        t_irq();
        t_fifo();
        t_wake();
        t_pin_reset();
        results();
    end
endmodule
`default_nettype wire
